// >>> core/psc_ctrl.sv
// Power switch state controller top level.
// Holds the global state and the per-device low-power flags.
// Assumes a raw front-panel switch pin, idle high through a pull-up,
// and one-cycle software command strobes from logic on clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "psc_params.svh"
// Function
// - Short press: off to work, work/sleep toggle
// - Long press from work/sleep forces soft-off
// - Otherwise change states only on software command
// - One switch means power or sleep by context
// - Software sets per-device low-power states while working
module psc_ctrl #(
  parameter int DEBOUNCE_CYC = `PSC_DEBOUNCE_CYC,
  parameter int LONG_CYC = `PSC_LONG_PRESS_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Front-panel switch pin, low while pressed
  input wire logic pwr_sw_n,
  // Software system commands, one-cycle strobes
  input wire logic sw_cmd_sleep,
  input wire logic sw_cmd_wake,
  input wire logic sw_cmd_off,
  // Software device power command
  input wire logic dev_cmd_valid,
  input wire logic [`PSC_NUM_DEV-1:0] dev_cmd_lowpwr,
  // State outputs
  output logic [1:0] sys_state,
  output logic main_power_en,
  output logic [`PSC_NUM_DEV-1:0] dev_lowpwr
);

  // Switch pin synchroniser
  logic sw_meta; // First stage, read by the second stage only
  logic sw_sync; // Second stage, high while pressed

  // Global state
  psc_pkg::psc_state_e state; // Current global state
  psc_pkg::psc_state_e next_state; // State taken at the next edge

  // Switch requests that apply in the current state
  logic go_off_press; // Long press while working or sleeping
  logic go_toggle_press; // Short press, meaning chosen by the state

  // Software requests that apply in the current state
  logic go_off_cmd; // Soft-off asked for while working or sleeping
  logic go_sleep_cmd; // Sleep asked for while working
  logic go_work_cmd; // Wake asked for while sleeping

  // Per-device power bookkeeping
  logic entering_work; // Work begins at the next edge
  logic staying_work; // Work continues across the next edge
  logic dev_take; // A device command loads at the next edge
  wire logic [`PSC_NUM_DEV-1:0] next_dev_lowpwr; // Device flags after the next edge

  // Device flag value after reset and on every fresh start of work
  localparam logic [`PSC_NUM_DEV-1:0] DEV_RST = `PSC_DEV_RST;

  // Press events between the timer and the state logic
  psc_press_if press ();

  // True in the working state; state, device and output logic all ask this
  function automatic logic is_work(input psc_pkg::psc_state_e s);
    return s == psc_pkg::PSC_WORK;
  endfunction : is_work

  // True where a long press or a soft-off command has an effect
  function automatic logic is_live(input psc_pkg::psc_state_e s);
    return (s == psc_pkg::PSC_WORK) || (s == psc_pkg::PSC_SLEEP);
  endfunction : is_live

  // Target of a short press: working goes to sleep, anything else to work
  // Unused codes would also go to work; the case below never asks for them
  function automatic psc_pkg::psc_state_e toggle_of(input psc_pkg::psc_state_e s);
    psc_pkg::psc_state_e t;
    t = psc_pkg::PSC_WORK;
    if (s == psc_pkg::PSC_WORK) begin
      t = psc_pkg::PSC_SLEEP;
    end
    return t;
  endfunction : toggle_of

  // Two-flop synchroniser for the switch pin; the pin idles high, so the
  // reset value matches a released switch and no false press follows reset
  // Nothing but sw_sync reads sw_meta
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sw_meta <= 1'b0;
      sw_sync <= 1'b0;
    end else begin
      sw_meta <= ~pwr_sw_n; // Invert: pressed becomes high
      sw_sync <= sw_meta;
    end
  end

  // Press duration measurement; debounce and both thresholds live here
  psc_press_timer #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sw_sync(sw_sync),
    .ev(press.timer)
  );

  // Qualify long presses and software strobes by the current state; a short press counts in every state
  always_comb begin
    // Switch events
    go_off_press = press.long_press && is_live(state);
    go_toggle_press = press.short_press;
    // Software strobes
    go_off_cmd = sw_cmd_off && is_live(state);
    go_sleep_cmd = sw_cmd_sleep && is_work(state);
    go_work_cmd = sw_cmd_wake && (state == psc_pkg::PSC_SLEEP);
  end

  // Priority, highest first:
  //   long press (fail-safe off)
  //   short press (power or sleep by state)
  //   software soft-off
  //   software sleep or wake
  // Next-state selection; switch events outrank software strobes, and a
  // long press outranks everything so the fail-safe off cannot be blocked
  always_comb begin
    next_state = state;
    case (state)
      psc_pkg::PSC_OFF: begin
        // Only a short press powers on; long presses and strobes are ignored
        if (go_toggle_press) begin
          next_state = toggle_of(state);
        end
      end
      psc_pkg::PSC_WORK: begin
        if (go_off_press) begin
          next_state = psc_pkg::PSC_OFF; // Fail-safe off
        end else if (go_toggle_press) begin
          next_state = toggle_of(state); // Short press sleeps
        end else if (go_off_cmd) begin
          next_state = psc_pkg::PSC_OFF; // Software soft-off
        end else if (go_sleep_cmd) begin
          next_state = psc_pkg::PSC_SLEEP; // Software sleep
        end
      end
      psc_pkg::PSC_SLEEP: begin
        if (go_off_press) begin
          next_state = psc_pkg::PSC_OFF; // Fail-safe off
        end else if (go_toggle_press) begin
          next_state = toggle_of(state); // Short press wakes
        end else if (go_off_cmd) begin
          next_state = psc_pkg::PSC_OFF; // Software soft-off
        end else if (go_work_cmd) begin
          next_state = psc_pkg::PSC_WORK; // Software wake
        end
      end
      default: begin
        // Unused code: fall back to soft-off
        next_state = psc_pkg::PSC_OFF;
      end
    endcase
  end

  // Global state register; comes up in soft-off
  // The enum covers three codes; the fourth is caught by the default branch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= psc_pkg::PSC_OFF;
    end else begin
      state <= next_state; // Every change but the unused-code fallback to soft-off was asked for
    end
  end

  // Device bookkeeping: when work starts afresh and when a command may load
  // A command in the same cycle as a state change is dropped, since the
  // change decides the flags on its own
  always_comb begin
    entering_work = is_work(next_state) && !is_work(state);
    staying_work = is_work(next_state) && is_work(state);
    dev_take = staying_work && dev_cmd_valid; // A command leaving work is dropped
  end

  // Next device flags, one slice per device
  // Each slice picks, in order: forced low power, fresh start, command, hold
  for (genvar d = 0; d < `PSC_NUM_DEV; d++) begin : g_dev
    // Outside work every device is held in low power; work restarts at reset value
    assign next_dev_lowpwr[d] = !is_work(next_state) ? 1'b1 :
      entering_work ? DEV_RST[d] :
      dev_take ? dev_cmd_lowpwr[d] : dev_lowpwr[d];
  end

  // Per-device power register; between state changes only software moves it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dev_lowpwr <= DEV_RST;
    end else begin
      dev_lowpwr <= next_dev_lowpwr;
    end
  end

  // Reported state; registered from the next state so it equals the state register
  // In reset it reads as the work code while power stays off until the first edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_state <= `PSC_SYS_STATE_RST;
    end else begin
      sys_state <= next_state;
    end
  end

  // Main power enable; high only while working
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      main_power_en <= `PSC_POWER_EN_RST;
    end else begin
      main_power_en <= is_work(next_state);
    end
  end
endmodule : psc_ctrl
`default_nettype wire

// >>> core/psc_params.svh
// Constants for the power switch state controller.
// Assumes a 50 MHz system clock.
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
`define PSC_CLK_HZ 50000000
`define PSC_LONG_PRESS_MS 4000
`define PSC_LONG_PRESS_CYC ((`PSC_CLK_HZ / 1000) * `PSC_LONG_PRESS_MS)
`define PSC_DEBOUNCE_US 10000
`define PSC_DEBOUNCE_CYC ((`PSC_CLK_HZ / 1000000) * `PSC_DEBOUNCE_US)
`define PSC_NUM_DEV 4
`define PSC_DEV_RST 4'h0
`define PSC_SYS_STATE_RST 2'h0
`define PSC_POWER_EN_RST 1'b0
`endif

// >>> core/psc_pkg.sv
// Types for the power switch state controller.
// Assumes nothing beyond the params header.
`default_nettype none
package psc_pkg;
  // Global power state
  typedef enum logic [1:0] {
    PSC_WORK = 2'b00,
    PSC_SLEEP = 2'b01,
    PSC_OFF = 2'b10
  } psc_state_e;
endpackage : psc_pkg
`default_nettype wire

// >>> core/psc_press_if.sv
// Interface carrying press events from the press timer to the state logic.
// Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
interface psc_press_if;
  logic short_press; // One-cycle pulse on release before threshold
  logic long_press;  // One-cycle pulse when threshold is reached
  modport timer (output short_press, output long_press);
  modport ctrl (input short_press, input long_press);
endinterface : psc_press_if
`default_nettype wire

// >>> core/psc_press_timer.sv
// Debounce and press-duration timer for the power switch.
// Assumes the switch input is already synchronised to clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "psc_params.svh"
module psc_press_timer #(
  parameter int DEBOUNCE_CYC = `PSC_DEBOUNCE_CYC,
  parameter int LONG_CYC = `PSC_LONG_PRESS_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Synchronised switch level, high while pressed
  input wire logic sw_sync,
  // Press events
  psc_press_if.timer ev
);
  logic sw_db;          // Debounced switch level
  logic [31:0] db_cnt;  // Stability counter
  logic [31:0] hold_cnt; // Press duration counter
  logic long_done;      // Long action already fired for this press

  // Debounce: accept a new level after it has been stable long enough
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sw_db <= 1'b0;
      db_cnt <= 32'h0000_0000;
    end else if (sw_sync == sw_db) begin
      db_cnt <= 32'h0000_0000;
    end else if (db_cnt >= 32'(DEBOUNCE_CYC - 1)) begin
      sw_db <= sw_sync;
      db_cnt <= 32'h0000_0000;
    end else begin
      db_cnt <= db_cnt + 32'h0000_0001;
    end
  end

  // Hold counter and event pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hold_cnt <= 32'h0000_0000;
      long_done <= 1'b0;
      ev.short_press <= 1'b0;
      ev.long_press <= 1'b0;
    end else begin
      ev.short_press <= 1'b0;
      ev.long_press <= 1'b0;
      if (sw_db) begin
        // Count while held; fire long action at threshold
        if (!long_done) begin
          if (hold_cnt >= 32'(LONG_CYC - 1)) begin
            ev.long_press <= 1'b1;
            long_done <= 1'b1;
          end else begin
            hold_cnt <= hold_cnt + 32'h0000_0001;
          end
        end
      end else begin
        // Released: short action only if threshold not reached
        if (hold_cnt != 32'h0000_0000 && !long_done) begin
          ev.short_press <= 1'b1;
        end
        hold_cnt <= 32'h0000_0000;
        long_done <= 1'b0;
      end
    end
  end
endmodule : psc_press_timer
`default_nettype wire

// >>> test/psc_ctrl_checker.sv
// Port assertions for the power switch state controller.
// Assumes binding onto psc_ctrl with its shortened counts.
`timescale 1ns/10ps
`default_nettype none
module psc_ctrl_checker #(
  parameter int DEBOUNCE_CYC = 4,
  parameter int LONG_CYC = 50
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports
  input wire logic pwr_sw_n,
  input wire logic sw_cmd_sleep,
  input wire logic sw_cmd_wake,
  input wire logic sw_cmd_off,
  input wire logic dev_cmd_valid,
  input wire logic [3:0] dev_cmd_lowpwr,
  input wire logic [1:0] sys_state,
  input wire logic main_power_en,
  input wire logic [3:0] dev_lowpwr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  localparam int LO_CAP = DEBOUNCE_CYC + LONG_CYC + 8; // Press span that must end in soft-off
  int hi; // Released cycles, stops at 64
  int lo; // Pressed cycles, stops at LO_CAP
  wire logic idle = hi >= 64; // No press event can still be due
  wire logic cmd = sw_cmd_sleep | sw_cmd_wake | sw_cmd_off;
  // Span counters of the switch pin
  always_ff @(posedge clk_sys) begin
    hi <= (!rst_n || !pwr_sw_n) ? 0 : (hi < 64 ? hi + 1 : hi);
    lo <= (!rst_n || pwr_sw_n) ? 0 : (lo < LO_CAP ? lo + 1 : lo);
  end
  a_off_cmd: assert property (idle && sw_cmd_off |=> sys_state == 2'h2)
    else $error("off missed");
  a_sleep_cmd: assert property (idle && sw_cmd_sleep && !sw_cmd_off && sys_state == 2'h0
    |=> sys_state == 2'h1) else $error("sleep missed");
  a_wake_cmd: assert property (idle && sw_cmd_wake && !sw_cmd_off && sys_state == 2'h1
    |=> sys_state == 2'h0) else $error("wake missed");
  a_no_self: assert property (idle && !cmd && !dev_cmd_valid
    |=> $stable(sys_state) && $stable(dev_lowpwr)) else $error("change uncommanded");
  a_power_en: assert property (idle |-> main_power_en == (sys_state == 2'h0))
    else $error("power enable wrong");
  a_dev_load: assert property (idle && dev_cmd_valid && !cmd && sys_state == 2'h0
    |=> dev_lowpwr == $past(dev_cmd_lowpwr)) else $error("device load missed");
  a_dev_asleep: assert property (sys_state != 2'h0 |-> dev_lowpwr == 4'hf)
    else $error("devices not low");
  a_work_entry: assert property (sys_state == 2'h0 && $past(sys_state) != 2'h0
    |-> dev_lowpwr == 4'h0) else $error("devices not cleared");
  a_long_off: assert property (lo == LO_CAP |-> sys_state == 2'h2)
    else $error("long press missed");
  c_sleep: cover property (sys_state == 2'h1);
  c_off: cover property (idle && sw_cmd_off);
  c_dev: cover property (dev_cmd_valid && sys_state == 2'h0);
endmodule : psc_ctrl_checker
bind psc_ctrl psc_ctrl_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .LONG_CYC(LONG_CYC))
  psc_ctrl_checker_i (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pwr_sw_n(pwr_sw_n),
    .sw_cmd_sleep(sw_cmd_sleep),
    .sw_cmd_wake(sw_cmd_wake),
    .sw_cmd_off(sw_cmd_off),
    .dev_cmd_valid(dev_cmd_valid),
    .dev_cmd_lowpwr(dev_cmd_lowpwr),
    .sys_state(sys_state),
    .main_power_en(main_power_en),
    .dev_lowpwr(dev_lowpwr)
  );
`default_nettype wire

// >>> test/psc_sw_model.sv
// Front-panel switch model, pulled up, low while pressed.
// Assumes callers enter press just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module psc_sw_model (
  // Clock
  input wire logic clk_sys,
  // Switch pin, low while pressed
  output logic pwr_sw_n
);
  initial pwr_sw_n = 1'b1;
  // Hold the button n cycles, then the pull-up returns it high
  task automatic press(input int n);
    pwr_sw_n = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1 pwr_sw_n = 1'b1;
  endtask : press
endmodule : psc_sw_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the power switch state controller.
// Assumes the bound checker and the switch model.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_sys = 0;
  logic rst_n = 0;
  logic sw_cmd_sleep = 0, sw_cmd_wake = 0, sw_cmd_off = 0, dev_cmd_valid = 0;
  logic [3:0] dev_cmd_lowpwr = 0;
  wire logic pwr_sw_n, main_power_en;
  wire logic [1:0] sys_state;
  wire logic [3:0] dev_lowpwr;
  logic [5:0] ex = 6'h2f; // Expected state and device flags
  int errors = 0;
  int n_tests = 0;
  int seq[9] = '{0, 5, 2, 3, 0, 1, 1, 6, 4}; // Corner cases, sleep and wake back to back
  psc_ctrl #(.DEBOUNCE_CYC(4), .LONG_CYC(50)) psc_ctrl_i (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pwr_sw_n(pwr_sw_n),
    .sw_cmd_sleep(sw_cmd_sleep),
    .sw_cmd_wake(sw_cmd_wake),
    .sw_cmd_off(sw_cmd_off),
    .dev_cmd_valid(dev_cmd_valid),
    .dev_cmd_lowpwr(dev_cmd_lowpwr),
    .sys_state(sys_state),
    .main_power_en(main_power_en),
    .dev_lowpwr(dev_lowpwr)
  );
  psc_sw_model psc_sw_model_i (.clk_sys(clk_sys), .pwr_sw_n(pwr_sw_n));
  initial forever #10 clk_sys = ~clk_sys;
  // Expected result: 0 short, 1 long, 2 sleep, 3 wake, 4 off, 5 device load, 6 bounce
  function automatic logic [5:0] nxt(input logic [5:0] e, input int k, input logic [3:0] v);
    logic [1:0] n;
    n = e[5:4];
    case (k)
      0: n = (n == 2'h0) ? 2'h1 : 2'h0;
      1, 4: n = 2'h2;
      2: n = (n == 2'h0) ? 2'h1 : n;
      3: n = (n == 2'h1) ? 2'h0 : n;
      default: ;
    endcase
    if (n != 2'h0) return {n, 4'hf};
    return {n, (e[5:4] != 2'h0) ? 4'h0 : (k == 5) ? v : e[3:0]};
  endfunction : nxt
  task automatic chk(input string s, input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // One operation entered just after an edge, checked once settled
  task automatic op(input int k);
    {dev_cmd_valid, sw_cmd_off, sw_cmd_wake, sw_cmd_sleep} =
      (k inside {[2:5]}) ? 4'h1 << (k - 2) : 4'h0;
    dev_cmd_lowpwr = 4'($urandom);
    ex = nxt(ex, k, dev_cmd_lowpwr);
    @(posedge clk_sys);
    #1;
    if (k < 2 || k == 6) begin
      psc_sw_model_i.press(k == 1 ? 80 : (k == 6 ? 2 : 20));
      repeat (70) @(posedge clk_sys);
      #1;
    end
    chk("state", {2'h0, ex[5:4]}, {2'h0, sys_state});
    chk("devices", ex[3:0], dev_lowpwr);
    chk("power", {3'h0, ex[5:4] == 2'h0}, {3'h0, main_power_en});
  endtask : op
  task automatic wrap_up();
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(32'hf245_25f6));
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1;
    repeat (70) @(posedge clk_sys);
    #1;
    chk("state", 4'h2, {2'h0, sys_state});
    chk("power", 4'h0, {3'h0, main_power_en});
    foreach (seq[i]) op(seq[i]);
    repeat (16) op(int'($urandom_range(6, 0)));
    op(6);
    wrap_up();
  end
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
